// ---- fp_control_status_trap_logic.sv ----
// fp control/status register, sticky flags, trap masking and rounding select
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module fp_control_status_trap_logic
    import fpcs_pkg::*;
(
    input  wire logic        sys_clk_i,           // core clock
    input  wire logic        rst_b_i,             // async reset, low
    input  wire logic        hsel_i,              // slave select
    input  wire logic [31:0] haddr_i,             // byte address
    input  wire logic [1:0]  htrans_i,            // transfer type
    input  wire logic        hwrite_i,            // write flag
    input  wire logic [2:0]  hsize_i,             // transfer size
    input  wire logic [31:0] hwdata_i,            // write data
    input  wire logic        hready_i,            // bus ready
    output logic      [31:0] hrdata_o,            // read data
    output logic             hreadyout_o,         // slave ready
    output logic             hresp_o,             // always okay
    input  wire fp_event_s   fp_event_i,          // completing operation
    output fp_verdict_s      fp_verdict_o,        // trap/result verdict
    output logic             denormal_input_flush_o, // flush denormal inputs
    output logic             any_exception_flag_o // summary bit
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [FLAG_N-1:0] flags_r,  flags_nxt;
    logic              inexact_trap_mask_r,   inexact_trap_mask_nxt;
    logic              underflow_trap_mask_r,   underflow_trap_mask_nxt;
    logic              underflow_flush_zero_r,   underflow_flush_zero_nxt;
    logic [1:0]        dyn_r,    dyn_nxt;
    logic              overflow_trap_mask_r,   overflow_trap_mask_nxt;
    logic              div_zero_trap_mask_r,   div_zero_trap_mask_nxt;
    logic              illegal_operand_trap_mask_r,   illegal_operand_trap_mask_nxt;
    logic              dnz_r,    dnz_nxt;
    logic              wr_pend_r;
    logic              wr_hi_r;
    logic [31:0]       hrdata_r;
    fp_verdict_s       verdict_r, verdict_nxt;
    logic              sum_r;
    logic              hready_r;
    logic              hresp_r;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    function automatic logic is_hi(input logic [31:0] a);
        is_hi = (a[ADDR_DEC_W-1:0] == ADDR_HI_OFS[ADDR_DEC_W-1:0]);
    endfunction

    wire        addr_ok  = is_hi(haddr_i) ||
                           (haddr_i[ADDR_DEC_W-1:0] == ADDR_LO_OFS[ADDR_DEC_W-1:0]);
    wire        take     = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
    wire        take_wr  = take && hwrite_i && addr_ok;
    wire        take_rd  = take && !hwrite_i;
    // writes land in the data phase; low word is all reserved
    wire        hi_write = wr_pend_r && wr_hi_r;
    wire [31:0] wd       = hwdata_i;

    // ---------------------------------------------------------------
    // event decode
    // ---------------------------------------------------------------
    wire [FLAG_N-1:0] ev_exc = fp_event_i.valid ? fp_event_i.exc : FLAGS_RST;
    wire ev_ine = ev_exc[EXC_INE];
    wire ev_unf = ev_exc[EXC_UNF];
    wire ev_ovf = ev_exc[EXC_OVF];
    wire ev_dze = ev_exc[EXC_DZE];
    wire ev_inv = ev_exc[EXC_INV];

    wire ine_trap = ev_ine && fp_event_i.ine_trap_en && !inexact_trap_mask_r;
    wire unf_zero = ev_unf && underflow_trap_mask_r && underflow_flush_zero_r;
    wire unf_trap = ev_unf && !unf_zero;
    wire ovf_trap = ev_ovf && !overflow_trap_mask_r;
    wire dze_trap = ev_dze && !div_zero_trap_mask_r;
    // invalid masked only when default is producible
    wire inv_trap = ev_inv && !(illegal_operand_trap_mask_r && fp_event_i.inv_default_ok);

    wire [FLAG_N-1:0] cause = {1'b0, ine_trap, unf_trap, ovf_trap, dze_trap, inv_trap};
    // masked inexact keeps its own rounded result, so no default substitution
    wire masked_dflt = (ev_ovf && !ovf_trap) || (ev_dze && !dze_trap) || (ev_inv && !inv_trap);

    // dynamic field only for dynamic-rounding instructions
    // codes pass through as the round_mode_e encoding
    wire round_mode_e rnd_sel = fp_event_i.dyn_round_req ? round_mode_e'(dyn_r)
                                                         : fp_event_i.static_round;

    // ---------------------------------------------------------------
    // register next state
    // ---------------------------------------------------------------
    // flags set by events
    // sticky, set wins over a same-cycle software write
    assign flags_nxt = (hi_write ? wd[FLAG_HI-WORD_W:FLAG_LO-WORD_W] : flags_r) | ev_exc;
    assign inexact_trap_mask_nxt  = hi_write ? wd[INEXACT_TRAP_MASK_POS-WORD_W] : inexact_trap_mask_r;
    assign underflow_trap_mask_nxt  = hi_write ? wd[UNDERFLOW_TRAP_MASK_POS-WORD_W] : underflow_trap_mask_r;
    assign underflow_flush_zero_nxt  = hi_write ? wd[UNDERFLOW_FLUSH_ZERO_POS-WORD_W] : underflow_flush_zero_r;
    assign dyn_nxt   = hi_write ? wd[DYN_HI-WORD_W:DYN_LO-WORD_W] : dyn_r;
    assign overflow_trap_mask_nxt  = hi_write ? wd[OVERFLOW_TRAP_MASK_POS-WORD_W] : overflow_trap_mask_r;
    assign div_zero_trap_mask_nxt  = hi_write ? wd[DIV_ZERO_TRAP_MASK_POS-WORD_W] : div_zero_trap_mask_r;
    assign illegal_operand_trap_mask_nxt  = hi_write ? wd[ILLEGAL_OPERAND_TRAP_MASK_POS-WORD_W] : illegal_operand_trap_mask_r;
    assign dnz_nxt   = hi_write ? wd[DNZ_POS-WORD_W] : dnz_r;

    // summary from next flags, so it never lags them
    // write data bit 63 is not used
    wire sum_nxt = |flags_nxt;

    // reserved bits and low word read zero
    wire [31:0] hi_view = {sum_nxt, inexact_trap_mask_nxt, underflow_trap_mask_nxt, underflow_flush_zero_nxt, dyn_nxt,
                           flags_nxt, overflow_trap_mask_nxt, div_zero_trap_mask_nxt, illegal_operand_trap_mask_nxt, dnz_nxt,
                           16'h0000};
    wire [31:0] rd_nxt  = (take_rd && is_hi(haddr_i)) ? hi_view : RDATA_ZERO;

    always_comb begin
        verdict_nxt                = '0;
        verdict_nxt.valid          = fp_event_i.valid;
        verdict_nxt.trap           = |cause;
        verdict_nxt.trap_cause     = cause;
        verdict_nxt.write_default  = masked_dflt;
        // masked underflow with flush writes +0.0
        verdict_nxt.write_pos_zero = unf_zero;
        verdict_nxt.round_mode     = rnd_sel;
    end

    // ---------------------------------------------------------------
    // flops
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_r <= FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sum_r <= CTRL_RST;
        end else begin
            sum_r <= sum_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            inexact_trap_mask_r <= CTRL_RST;
        end else begin
            inexact_trap_mask_r <= inexact_trap_mask_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            underflow_trap_mask_r <= CTRL_RST;
        end else begin
            underflow_trap_mask_r <= underflow_trap_mask_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            underflow_flush_zero_r <= CTRL_RST;
        end else begin
            underflow_flush_zero_r <= underflow_flush_zero_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dyn_r <= DYN_RST;
        end else begin
            dyn_r <= dyn_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            overflow_trap_mask_r <= CTRL_RST;
        end else begin
            overflow_trap_mask_r <= overflow_trap_mask_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_zero_trap_mask_r <= CTRL_RST;
        end else begin
            div_zero_trap_mask_r <= div_zero_trap_mask_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            illegal_operand_trap_mask_r <= CTRL_RST;
        end else begin
            illegal_operand_trap_mask_r <= illegal_operand_trap_mask_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dnz_r <= CTRL_RST;
        end else begin
            dnz_r <= dnz_nxt;
        end
    end

    // zero-wait slave: every transfer completes in its data phase
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_pend_r <= 1'b0;
        end else begin
            wr_pend_r <= take_wr;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_hi_r <= 1'b0;
        end else begin
            wr_hi_r <= is_hi(haddr_i);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hrdata_r <= RDATA_ZERO;
        end else begin
            hrdata_r <= rd_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            verdict_r <= '0;
        end else begin
            verdict_r <= verdict_nxt;
        end
    end

    // ready rises one edge after reset release; masters wait on it
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hready_r <= 1'b0;
        end else begin
            hready_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
        end
    end

    assign hrdata_o               = hrdata_r;
    assign hreadyout_o            = hready_r;
    assign hresp_o                = hresp_r;
    assign fp_verdict_o           = verdict_r;
    // flush level to the operand unpacker
    assign denormal_input_flush_o = dnz_r;
    assign any_exception_flag_o   = sum_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_summary_or_flags: assert property (sum_r == (|flags_r))
        else $error("summary differs from flag OR");
    a_summary_no_write: assert property (
        (hi_write && wd[SUM_POS-WORD_W] && !(|flags_nxt)) |=> !sum_r)
        else $error("summary taken from write data");
    a_flag_sticky: assert property (
        (fp_event_i.valid && (|fp_event_i.exc)) |=> ((flags_r & $past(fp_event_i.exc)) == $past(fp_event_i.exc)))
        else $error("event flag not set");
    a_flag_hold: assert property (
        (!hi_write && flags_r[EXC_UNF]) |=> flags_r[EXC_UNF])
        else $error("underflow flag dropped");
    a_unf_unmasked: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_UNF] && !underflow_trap_mask_r) |=> (fp_verdict_o.trap && !fp_verdict_o.write_pos_zero))
        else $error("unmasked underflow did not trap");
    a_unf_noflush: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_UNF] && underflow_trap_mask_r && !underflow_flush_zero_r) |=> fp_verdict_o.trap_cause[EXC_UNF])
        else $error("underflow without flush did not trap");
    a_unf_zero: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_UNF] && underflow_trap_mask_r && underflow_flush_zero_r) |=> (fp_verdict_o.write_pos_zero && !fp_verdict_o.trap_cause[EXC_UNF]))
        else $error("flushed underflow not zeroed");
    a_ine_masked: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_INE] && inexact_trap_mask_r) |=> !fp_verdict_o.trap_cause[EXC_INE])
        else $error("masked inexact trapped");
    a_dyn_round_sel: assert property (
        (fp_event_i.valid && fp_event_i.dyn_round_req) |=> (fp_verdict_o.round_mode == $past(dyn_r)))
        else $error("dynamic rounding not applied");
    a_inv_default: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_INV] && !fp_event_i.inv_default_ok) |=> fp_verdict_o.trap)
        else $error("invalid without default did not trap");
    a_low_reads_zero: assert property (
        (take_rd && !is_hi(haddr_i)) |=> (hrdata_o == RDATA_ZERO))
        else $error("reserved word not zero");
    a_round_codes: assert property (
        (fp_event_i.valid && fp_event_i.dyn_round_req && dyn_r == RND_MINUS) |=> fp_verdict_o.round_mode == RND_MINUS)
        else $error("rounding code misdecoded");
    a_static_round: assert property (
        (fp_event_i.valid && !fp_event_i.dyn_round_req) |=> fp_verdict_o.round_mode == $past(fp_event_i.static_round))
        else $error("static rounding overridden");
    a_iov_sets: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_IOV]) |=> (flags_r[EXC_IOV] && !fp_verdict_o.trap_cause[EXC_IOV]))
        else $error("conversion overflow flag wrong");
    a_ine_sets: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_INE]) |=> flags_r[EXC_INE])
        else $error("inexact flag not set");
    a_unf_sets: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_UNF]) |=> flags_r[EXC_UNF])
        else $error("underflow flag not set");
    a_ovf_sets: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_OVF]) |=> flags_r[EXC_OVF])
        else $error("overflow flag not set");
    a_dze_sets: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_DZE]) |=> flags_r[EXC_DZE])
        else $error("divide-zero flag not set");
    a_inv_sets: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_INV]) |=> flags_r[EXC_INV])
        else $error("invalid flag not set");
    a_ine_unmasked: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_INE] && fp_event_i.ine_trap_en && !inexact_trap_mask_r) |=> fp_verdict_o.trap)
        else $error("unmasked inexact did not trap");
    a_ovf_masked: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_OVF] && overflow_trap_mask_r) |=> fp_verdict_o.write_default)
        else $error("masked overflow no default");
    a_dze_masked: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_DZE] && div_zero_trap_mask_r) |=> fp_verdict_o.write_default)
        else $error("masked divide-zero no default");
    a_inv_masked: assert property (
        (fp_event_i.valid && fp_event_i.exc[EXC_INV] && illegal_operand_trap_mask_r && fp_event_i.inv_default_ok) |=> fp_verdict_o.write_default)
        else $error("masked invalid no default");
    a_flush_level: assert property (
        hi_write |=> denormal_input_flush_o == $past(hwdata_i[DNZ_POS-WORD_W]))
        else $error("flush bit not written");
    a_write_fields: assert property (
        (hi_write && !fp_event_i.valid) |=> flags_r == $past(hwdata_i[FLAG_HI-WORD_W:FLAG_LO-WORD_W]))
        else $error("flag write not applied");
endmodule

`default_nettype wire

// ---- fp_control_status_trap_logic_test.sv ----
// self-checking bench for the fp control/status register block
`timescale 1ns/1ps
`default_nettype none
module fp_control_status_trap_logic_test;
    import fpcs_pkg::*;
    logic        sys_clk;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    fp_event_s   ev;
    fp_verdict_s vd;
    logic        denormal_input_flush;
    logic        sum;
    logic [31:0] rd;
    int          miscompares;
    int          n_tests;

    fp_control_status_trap_logic i_fp_control_status_trap_logic (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .fp_event_i(ev), .fp_verdict_o(vd),
        .denormal_input_flush_o(denormal_input_flush), .any_exception_flag_o(sum));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ---------------------------------------------------------------
    // compares and bus access
    // ---------------------------------------------------------------
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_verdict(input fp_verdict_s exp);
        n_tests++;
        if (vd !== exp) begin
            miscompares++;
            $display("mismatch at %0t: verdict %h expected %h", $time, vd, exp);
        end
    endtask

    // hsel stays high; idle cycles carry htrans idle
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check32(rd, exp);
    endtask

    // one operation pulse, then the registered verdict
    task automatic fire(input logic [5:0] exc, input logic inexact_flag, input logic ok, input logic dr,
                        input round_mode_e sr, input fp_verdict_s exp);
        int n;
        ev <= '{1'b1, exc, inexact_flag, ok, dr, sr};
        @(posedge sys_clk);
        ev.valid <= 1'b0;
        #1;
        n = 0;
        while (vd.valid !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check_verdict(exp);
        @(posedge sys_clk);
    endtask

    task automatic tcase(input logic [31:0] w, input logic [5:0] exc, input logic ok,
                         input logic trap, input logic wdef, input logic wz);
        wr(ADDR_HI_OFS, w);
        fire(exc, 1'b1, ok, 1'b0, RND_MINUS, '{1'b1, trap, trap ? exc : 6'h0, wdef, wz, RND_MINUS});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        rst_b = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
        ev = '0; miscompares = 0; n_tests = 0;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rdc(ADDR_HI_OFS, 32'h0800_0000);
        wr(ADDR_LO_OFS, 32'hffff_ffff);
        rdc(ADDR_LO_OFS, 32'h0);
        rdc(32'h0000_0008, 32'h0);
        check32({31'h0, hresp}, 32'h0);
        $display("test reset_map done");
        wr(ADDR_HI_OFS, 32'hffff_ffff);
        rdc(ADDR_HI_OFS, 32'hffff_0000);
        check32({31'h0, sum}, 32'h1);
        check32({31'h0, denormal_input_flush}, 32'h1);
        wr(ADDR_HI_OFS, 32'h8000_0000);
        rdc(ADDR_HI_OFS, 32'h0);
        check32({31'h0, sum}, 32'h0);
        $display("test write_fields done");
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_HI_OFS, 32'h0800_0000);
            fire(6'h1 << i, 1'b1, 1'b0, 1'b0, RND_PLUS,
                 '{1'b1, i != 5, (i == 5) ? 6'h0 : 6'h1 << i, 1'b0, 1'b0, RND_PLUS});
            rdc(ADDR_HI_OFS, 32'h8800_0000 | (32'h1 << (20 + i)));
        end
        fire(6'h0, 1'b0, 1'b0, 1'b0, RND_PLUS, '{1'b1, 1'b0, 6'h0, 1'b0, 1'b0, RND_PLUS});
        rdc(ADDR_HI_OFS, 32'h8a00_0000);
        check32({31'h0, sum}, 32'h1);
        $display("test sticky_flags done");
        tcase(32'h1800_0000, 6'h08, 1'b0, 1'b1, 1'b0, 1'b0);
        tcase(32'h2800_0000, 6'h08, 1'b0, 1'b1, 1'b0, 1'b0);
        tcase(32'h3800_0000, 6'h08, 1'b0, 1'b0, 1'b0, 1'b1);
        tcase(32'h4800_0000, 6'h10, 1'b0, 1'b0, 1'b0, 1'b0);
        tcase(32'h0808_0000, 6'h04, 1'b0, 1'b0, 1'b1, 1'b0);
        tcase(32'h0804_0000, 6'h02, 1'b0, 1'b0, 1'b1, 1'b0);
        tcase(32'h0802_0000, 6'h01, 1'b1, 1'b0, 1'b1, 1'b0);
        tcase(32'h0802_0000, 6'h01, 1'b0, 1'b1, 1'b0, 1'b0);
        $display("test trap_masks done");
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_HI_OFS, 32'(k) << 26);
            rdc(ADDR_HI_OFS, 32'(k) << 26);
            fire(6'h0, 1'b0, 1'b0, 1'b1, round_mode_e'(2'(3 - k)),
                 '{1'b1, 1'b0, 6'h0, 1'b0, 1'b0, round_mode_e'(2'(k))});
            fire(6'h0, 1'b0, 1'b0, 1'b0, round_mode_e'(2'(3 - k)),
                 '{1'b1, 1'b0, 6'h0, 1'b0, 1'b0, round_mode_e'(2'(3 - k))});
        end
        $display("test rounding done");
        tally_and_finish;
    end

    // bench needs about 130 cycles; hang cut well beyond that
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish;
    end
endmodule
`default_nettype wire

// ---- fpcs_pkg.sv ----
// shared constants and carrier types for the fp control/status block
package fpcs_pkg;
    // ---------------------------------------------------------------
    // bus map
    // ---------------------------------------------------------------
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] ADDR_LO_OFS   = 32'h0000_0000;
    localparam logic [31:0] ADDR_HI_OFS   = 32'h0000_0004;
    localparam int          ADDR_DEC_W    = 8;
    localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
    // ---------------------------------------------------------------
    // field positions, 64-bit numbering
    // ---------------------------------------------------------------
    localparam int SUM_POS   = 63;
    localparam int INEXACT_TRAP_MASK_POS  = 62;
    localparam int UNDERFLOW_TRAP_MASK_POS  = 61;
    localparam int UNDERFLOW_FLUSH_ZERO_POS  = 60;
    localparam int DYN_HI    = 59;
    localparam int DYN_LO    = 58;
    localparam int FLAG_HI   = 57;
    localparam int FLAG_LO   = 52;
    localparam int OVERFLOW_TRAP_MASK_POS  = 51;
    localparam int DIV_ZERO_TRAP_MASK_POS  = 50;
    localparam int ILLEGAL_OPERAND_TRAP_MASK_POS  = 49;
    localparam int DNZ_POS   = 48;
    localparam int WORD_W    = 32;
    localparam int FLAG_N    = 6;
    // index into the six-bit flag vector (flag bit = FLAG_LO + index)
    localparam int EXC_INV   = 0;
    localparam int EXC_DZE   = 1;
    localparam int EXC_OVF   = 2;
    localparam int EXC_UNF   = 3;
    localparam int EXC_INE   = 4;
    localparam int EXC_IOV   = 5;
    // reset values (not defined by the architecture; all clear except the dynamic rounding field, which resets to nearest)
    localparam logic [FLAG_N-1:0] FLAGS_RST = 6'h00;
    localparam logic [1:0]        DYN_RST   = 2'h2;
    localparam logic              CTRL_RST  = 1'b0;

    typedef enum logic [1:0] {
        RND_CHOPPED = 2'b00,
        RND_MINUS   = 2'b01,
        RND_NEAREST = 2'b10,
        RND_PLUS    = 2'b11
    } round_mode_e;

    // one completing fp operation from the execution datapath
    typedef struct packed {
        logic              valid;
        logic [FLAG_N-1:0] exc;
        logic              ine_trap_en;
        logic              inv_default_ok;
        logic              dyn_round_req;
        round_mode_e       static_round;
    } fp_event_s;

    // verdict returned to the datapath
    typedef struct packed {
        logic              valid;
        logic              trap;
        logic [FLAG_N-1:0] trap_cause;
        logic              write_default;
        logic              write_pos_zero;
        round_mode_e       round_mode;
    } fp_verdict_s;
endpackage
